// *** include/wdog_pkg.sv ***
// constants for the watchdog and alarm interrupt block of the timekeeping ram
// assumes a 100 mhz sys_clk; all other modules import this package whole
package wdog_pkg;
   // -------------------------------------------------------------
   // register map on the bytewide port
   // -------------------------------------------------------------
   localparam int ADDR_W = 13;
   localparam logic [12:0] FLAGS_ADDR = 13'h1ff0;
   localparam logic [12:0] FTREG_ADDR = 13'h1ff1;
   localparam logic [12:0] IRQEN_ADDR = 13'h1ff6;
   localparam logic [12:0] WD_ADDR = 13'h1ff7;
   localparam logic [7:0] WD_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int STEER_BIT = 7;
   localparam int MULT_MSB = 6;
   localparam int MULT_LSB = 2;
   localparam int RES_MSB = 1;
   localparam int RES_LSB = 0;
   localparam int AE_BIT = 7;
   localparam int ABE_BIT = 5;
   localparam int WF_BIT = 7;
   localparam int AF_BIT = 6;
   localparam int FT_BIT = 0;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam longint CLK_HZ = 100_000_000;
   localparam longint SUBTICK_HZ = 1024;
   // longest whole count for one 1/1024 s subtick
   localparam longint SUBTICK_CYCLES = CLK_HZ / SUBTICK_HZ;
   localparam int PERIOD_W = 18;
   localparam logic [PERIOD_W-1:0] RES_TICKS_0 = PERIOD_W'(SUBTICK_HZ / 16);
   localparam logic [PERIOD_W-1:0] RES_TICKS_1 = PERIOD_W'(SUBTICK_HZ / 4);
   localparam logic [PERIOD_W-1:0] RES_TICKS_2 = PERIOD_W'(SUBTICK_HZ);
   localparam logic [PERIOD_W-1:0] RES_TICKS_3 = PERIOD_W'(SUBTICK_HZ * 4);
   localparam int RST_PULSE_MS = 100;
   localparam int PULSE_W = 7;
   localparam logic [PULSE_W-1:0] RST_PULSE_TICKS = PULSE_W'(RST_PULSE_MS * SUBTICK_HZ / 1000);
   localparam logic [PULSE_W-1:0] PULSE_ONE = 7'h01;
endpackage : wdog_pkg

// *** src/subtick_divider.sv ***
// free divider that turns sys_clk into a one-cycle subtick pulse
// assumes run is a level synchronous to sys_clk (oscillator running)
`timescale 1ns/1ps
module subtick_divider
   import wdog_pkg::*;
#(
   parameter longint DIV = SUBTICK_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // control and result
   input wire logic run,
   output logic tick
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_ff;
   logic tick_ff;

   // stopped oscillator freezes the phase rather than restarting it
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else if (run) begin
         cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
         tick_ff <= (cnt_ff == LAST);
      end else begin
         tick_ff <= 1'b0;
      end
   end

   assign tick = tick_ff;
endmodule : subtick_divider

// *** src/watchdog_alarm_irq.sv ***
// watchdog timer and alarm interrupt / frequency test output logic
// assumes bytewide port pins and status inputs are synchronous to sys_clk
//
// How it works
// - on battery, alarm interrupt needs both enables
// - power-up clears enables; alarm flag still sets
// - 8-bit register, five-bit multiplier below steer
// - two low bits pick 1/16,1/4,1,4 s
// - period is multiplier times resolution step
// - timeout sets flag, interrupt held until access
// - steer zero: timeout drives interrupt output
// - steer one: reset pulse of 40-200 ms
// - after reset pulse clear register and test
// - any watchdog register access restarts the period
// - register zero disables the watchdog
// - power-on clears watchdog fields and enables
// - watchdog interrupt beats frequency test wave
// - 512 hz test wave under its conditions
// - alarm match sets flag, interrupts if enabled
// - flags access releases alarm interrupt at end
`timescale 1ns/1ps
module watchdog_alarm_irq
   import wdog_pkg::*;
#(
   parameter longint SUBTICK_DIV = SUBTICK_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // bytewide host port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] dq_in,
   output logic [7:0] dq_out,
   output logic dq_oe,
   input wire logic chip_en_n,
   input wire logic out_en_n,
   input wire logic wr_en_n,
   // device status
   input wire logic on_battery,
   input wire logic power_up,
   input wire logic osc_running,
   input wire logic alarm_match,
   // open-drain pins, enable high while pulling low
   output logic alarm_irq_freqtest_out_n,
   output logic alarm_irq_freqtest_oe,
   output logic wd_reset_out_n,
   output logic wd_reset_oe
);
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   logic [7:0] wd_reg_ff;
   logic [PERIOD_W-1:0] wd_cnt_ff;
   logic [PULSE_W-1:0] pulse_cnt_ff;
   logic pulse_busy_ff, alarm_irq_enable_ff, backup_alarm_enable_ff, freq_test_bit_ff;
   logic watchdog_timeout_flag_ff, alarm_match_flag_ff, wd_irq_ff, alarm_irq_ff;
   logic flags_acc_ff, square_ff, irq_low_ff;
   logic [7:0] dq_out_ff;
   logic dq_oe_ff;
   // combinational decode and arithmetic
   logic tick, acc, wr, rd, wd_acc, flags_end;
   logic wd_enabled, timeout, pulse_end, ft_active, steer;
   logic [PERIOD_W-1:0] step, period;

   subtick_divider #(
      .DIV(SUBTICK_DIV)
   ) u_div (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .run(osc_running),
      .tick(tick)
   );
   // -------------------------------------------------------------
   // access decode
   // -------------------------------------------------------------
   assign acc = !chip_en_n && (!wr_en_n || !out_en_n);
   assign wr = !chip_en_n && !wr_en_n;
   assign rd = acc && wr_en_n;
   assign wd_acc = acc && (addr == WD_ADDR);
   // flag side effects wait for the access to finish
   assign flags_end = flags_acc_ff && !(acc && (addr == FLAGS_ADDR));

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flags_acc_ff <= 1'b0;
      end else begin
         flags_acc_ff <= acc && (addr == FLAGS_ADDR);
      end
   end

   // -------------------------------------------------------------
   // timeout arithmetic
   // -------------------------------------------------------------
   assign steer = wd_reg_ff[STEER_BIT];
   assign wd_enabled = (wd_reg_ff[MULT_MSB:MULT_LSB] != '0);

   always_comb begin
      unique case (wd_reg_ff[RES_MSB:RES_LSB])
         2'h0: step = RES_TICKS_0;
         2'h1: step = RES_TICKS_1;
         2'h2: step = RES_TICKS_2;
         2'h3: step = RES_TICKS_3;
      endcase
   end

   assign period = PERIOD_W'(wd_reg_ff[MULT_MSB:MULT_LSB] * step);
   // counting pauses while a reset pulse is out, so pulses never overlap
   assign timeout = wd_enabled && tick && !pulse_busy_ff && !wd_acc && (wd_cnt_ff == period - 1'b1);
   assign pulse_end = pulse_busy_ff && tick && (pulse_cnt_ff == PULSE_ONE);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wd_cnt_ff <= '0;
      end else if (wd_acc || timeout || !wd_enabled) begin
         wd_cnt_ff <= '0;
      end else if (tick && !pulse_busy_ff) begin
         wd_cnt_ff <= wd_cnt_ff + 1'b1;
      end
   end

   // -------------------------------------------------------------
   // registers written by the host
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wd_reg_ff <= WD_RESET;
      end else if (power_up || pulse_end) begin
         wd_reg_ff <= WD_RESET;
      end else if (wr && addr == WD_ADDR) begin
         wd_reg_ff <= dq_in;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         alarm_irq_enable_ff <= 1'b0;
         backup_alarm_enable_ff <= 1'b0;
      end else if (power_up) begin
         alarm_irq_enable_ff <= 1'b0;
         backup_alarm_enable_ff <= 1'b0;
      end else if (wr && addr == IRQEN_ADDR) begin
         alarm_irq_enable_ff <= dq_in[AE_BIT];
         backup_alarm_enable_ff <= dq_in[ABE_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         freq_test_bit_ff <= 1'b0;
      end else if (power_up || pulse_end) begin
         freq_test_bit_ff <= 1'b0;
      end else if (wr && addr == FTREG_ADDR) begin
         freq_test_bit_ff <= dq_in[FT_BIT];
      end
   end

   // -------------------------------------------------------------
   // flags and held interrupts; a set in the clearing cycle wins
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         watchdog_timeout_flag_ff <= 1'b0;
         wd_irq_ff <= 1'b0;
      end else begin
         watchdog_timeout_flag_ff <= timeout || (watchdog_timeout_flag_ff && !flags_end);
         wd_irq_ff <= (timeout && !steer) || (wd_irq_ff && !flags_end && !wd_acc);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         alarm_match_flag_ff <= 1'b0;
         alarm_irq_ff <= 1'b0;
      end else begin
         // flag sets even during power-up so software sees it afterwards
         alarm_match_flag_ff <= alarm_match || (alarm_match_flag_ff && !flags_end);
         alarm_irq_ff <= (alarm_match && alarm_irq_enable_ff && (!on_battery || backup_alarm_enable_ff))
                         || (alarm_irq_ff && !flags_end);
      end
   end

   // -------------------------------------------------------------
   // reset pulse
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pulse_busy_ff <= 1'b0;
         pulse_cnt_ff <= '0;
      end else if (timeout && steer) begin
         pulse_busy_ff <= 1'b1;
         pulse_cnt_ff <= RST_PULSE_TICKS;
      end else if (pulse_end) begin
         pulse_busy_ff <= 1'b0;
      end else if (pulse_busy_ff && tick) begin
         pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
      end
   end

   // -------------------------------------------------------------
   // frequency test and output pins
   // -------------------------------------------------------------
   assign ft_active = freq_test_bit_ff && !alarm_irq_enable_ff && osc_running
                      && (steer || wd_reg_ff == WD_RESET);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         square_ff <= 1'b0;
      end else if (!ft_active) begin
         square_ff <= 1'b0;
      end else if (tick) begin
         square_ff <= !square_ff;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq_low_ff <= 1'b0;
      end else begin
         irq_low_ff <= wd_irq_ff || alarm_irq_ff || (ft_active && square_ff && !wd_irq_ff);
      end
   end

   // -------------------------------------------------------------
   // read data
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dq_out_ff <= BYTE_ZERO;
         dq_oe_ff <= 1'b0;
      end else begin
         dq_out_ff <= BYTE_ZERO;
         dq_oe_ff <= 1'b0;
         if (rd) begin
            unique case (addr)
               WD_ADDR: begin
                  dq_out_ff <= wd_reg_ff;
                  dq_oe_ff <= 1'b1;
               end
               IRQEN_ADDR: begin
                  dq_out_ff[AE_BIT] <= alarm_irq_enable_ff;
                  dq_out_ff[ABE_BIT] <= backup_alarm_enable_ff;
                  dq_oe_ff <= 1'b1;
               end
               FLAGS_ADDR: begin
                  dq_out_ff[WF_BIT] <= watchdog_timeout_flag_ff;
                  dq_out_ff[AF_BIT] <= alarm_match_flag_ff;
                  dq_oe_ff <= 1'b1;
               end
               FTREG_ADDR: begin
                  dq_out_ff[FT_BIT] <= freq_test_bit_ff;
                  dq_oe_ff <= 1'b1;
               end
               // other addresses belong to the ram and clock, not here
               default: dq_oe_ff <= 1'b0;
            endcase
         end
      end
   end

   // open-drain data levels only ever pull low
   assign dq_out = dq_out_ff;
   assign dq_oe = dq_oe_ff;
   assign alarm_irq_freqtest_out_n = 1'b0;
   assign alarm_irq_freqtest_oe = irq_low_ff;
   assign wd_reset_out_n = 1'b0;
   assign wd_reset_oe = pulse_busy_ff;
   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   property p_batt_gate;
      @(posedge sys_clk) disable iff (!rst_n)
      alarm_match && on_battery && !backup_alarm_enable_ff && !alarm_irq_ff |=> !alarm_irq_ff;
   endproperty
   a_batt_gate: assert property (p_batt_gate) else $error("battery alarm without backup enable");

   property p_powerup;
      @(posedge sys_clk) disable iff (!rst_n)
      power_up && alarm_match |=> !alarm_irq_enable_ff && !backup_alarm_enable_ff && alarm_match_flag_ff;
   endproperty
   a_powerup: assert property (p_powerup) else $error("power-up enables or alarm flag wrong");

   property p_timeout_flag;
      @(posedge sys_clk) disable iff (!rst_n)
      timeout |=> watchdog_timeout_flag_ff && wd_cnt_ff == '0;
   endproperty
   a_timeout_flag: assert property (p_timeout_flag) else $error("timeout did not set flag");
   property p_timeout_period;
      @(posedge sys_clk) disable iff (!rst_n)
      timeout |-> wd_cnt_ff
                  == PERIOD_W'(wd_reg_ff[MULT_MSB:MULT_LSB] * (RES_TICKS_0 << (2 * wd_reg_ff[RES_MSB:RES_LSB]))) - 1'b1;
   endproperty
   a_timeout_period: assert property (p_timeout_period) else $error("timeout at wrong count");

   property p_irq_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      wd_irq_ff && !flags_end && !wd_acc |=> wd_irq_ff ##1 irq_low_ff;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("watchdog interrupt dropped early");

   property p_steer_irq;
      @(posedge sys_clk) disable iff (!rst_n)
      timeout && !steer |=> ##1 alarm_irq_freqtest_oe;
   endproperty
   a_steer_irq: assert property (p_steer_irq) else $error("interrupt pin not driven on timeout");
   property p_steer_rst;
      @(posedge sys_clk) disable iff (!rst_n)
      timeout && steer |=> wd_reset_oe && !wd_irq_ff;
   endproperty
   a_steer_rst: assert property (p_steer_rst) else $error("reset pulse not started");

   property p_pulse_clear;
      @(posedge sys_clk) disable iff (!rst_n)
      pulse_end |=> wd_reg_ff == WD_RESET && !freq_test_bit_ff && !wd_reset_oe;
   endproperty
   a_pulse_clear: assert property (p_pulse_clear) else $error("register not cleared after pulse");

   property p_restart;
      @(posedge sys_clk) disable iff (!rst_n)
      wd_acc |=> wd_cnt_ff == '0 && !wd_irq_ff;
   endproperty
   a_restart: assert property (p_restart) else $error("access did not restart watchdog");
   property p_disabled;
      @(posedge sys_clk) disable iff (!rst_n)
      wd_reg_ff[MULT_MSB:MULT_LSB] == '0 |-> !timeout ##1 wd_cnt_ff == '0;
   endproperty
   a_disabled: assert property (p_disabled) else $error("timeout while disabled");
   property p_flags_release;
      @(posedge sys_clk) disable iff (!rst_n)
      flags_end && !alarm_match |=> !alarm_irq_ff && !alarm_match_flag_ff;
   endproperty
   a_flags_release: assert property (p_flags_release) else $error("flags access did not release");

   property p_wd_priority;
      @(posedge sys_clk) disable iff (!rst_n)
      wd_irq_ff |=> alarm_irq_freqtest_oe;
   endproperty
   a_wd_priority: assert property (p_wd_priority) else $error("test wave overrode watchdog");
endmodule : watchdog_alarm_irq

// *** bench/host_bus_model.sv ***
// host processor model driving the bytewide port of the watchdog block
// assumes the bench calls wr and rd; strobes change only at falling edges
`timescale 1ns/1ps
module host_bus_model
   import wdog_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // bytewide port
   output logic [ADDR_W-1:0] addr,
   output logic [7:0] dq_in,
   output logic chip_en_n,
   output logic out_en_n,
   output logic wr_en_n,
   input wire logic [7:0] dq_out,
   input wire logic dq_oe
);
   initial begin
      addr = '0;
      dq_in = 8'h5a;
      chip_en_n = 1'b1;
      out_en_n = 1'b1;
      wr_en_n = 1'b1;
   end

   // released data lines show the inverse of the last value, not a stale copy
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      addr = a;
      dq_in = d;
      chip_en_n = 1'b0;
      wr_en_n = 1'b0;
      @(negedge sys_clk);
      chip_en_n = 1'b1;
      wr_en_n = 1'b1;
      dq_in = ~d;
   endtask : wr

   // read data is registered, so it is taken one cycle after the strobes
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d, output logic oe);
      @(negedge sys_clk);
      addr = a;
      chip_en_n = 1'b0;
      out_en_n = 1'b0;
      @(negedge sys_clk);
      d = dq_out;
      oe = dq_oe;
      chip_en_n = 1'b1;
      out_en_n = 1'b1;
   endtask : rd
endmodule : host_bus_model

// *** bench/tb_watchdog_alarm_irq.sv ***
// self-checking bench for the watchdog and alarm interrupt block
// assumes wdog_pkg and host_bus_model; subtick shortened to 4 clocks
`timescale 1ns/1ps
module tb_watchdog_alarm_irq
   import wdog_pkg::*;
;
   localparam int SUB = 4;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic on_battery = 1'b0;
   logic power_up = 1'b0;
   logic osc_running = 1'b1;
   logic alarm_match = 1'b0;
   logic [ADDR_W-1:0] addr;
   logic [7:0] dq_in, dq_out, d;
   logic chip_en_n, out_en_n, wr_en_n, dq_oe, oe;
   logic irq_out_n, irq_oe, rst_out_n, rst_oe;
   logic [7:0] cfg [4] = '{8'h04, 8'h09, 8'h06, 8'h07};
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   int i, n, p;
   // open-drain pins with pull-ups
   wire irq_pin = irq_oe ? irq_out_n : 1'b1;
   wire rst_pin = rst_oe ? rst_out_n : 1'b1;

   always #5 sys_clk = ~sys_clk;

   host_bus_model host (.sys_clk(sys_clk), .addr(addr), .dq_in(dq_in), .chip_en_n(chip_en_n),
      .out_en_n(out_en_n), .wr_en_n(wr_en_n), .dq_out(dq_out), .dq_oe(dq_oe));

   watchdog_alarm_irq #(.SUBTICK_DIV(SUB)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
      .wr_en_n(wr_en_n), .on_battery(on_battery), .power_up(power_up), .osc_running(osc_running),
      .alarm_match(alarm_match), .alarm_irq_freqtest_out_n(irq_out_n),
      .alarm_irq_freqtest_oe(irq_oe), .wd_reset_out_n(rst_out_n), .wd_reset_oe(rst_oe));

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task automatic report_and_stop;
      if (err_total == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input logic [7:0] mask);
      host.rd(a, d, oe);
      check({oe, d & mask}, {1'b1, exp}, "read");
   endtask : rd_chk

   // bounded wait for a pin to be pulled low; cnt is the cycles spent
   task automatic wait_lo(input logic rs, input int lim, output int cnt);
      cnt = 0;
      while (((rs ? rst_pin : irq_pin) !== 1'b0) && cnt < lim) begin
         @(negedge sys_clk);
         cnt++;
      end
   endtask : wait_lo

   task automatic count_tog(input int len, output int cnt);
      logic last;
      cnt = 0;
      last = irq_pin;
      repeat (len) begin
         @(negedge sys_clk);
         if (irq_pin !== last)
            cnt++;
         last = irq_pin;
      end
   endtask : count_tog

   task automatic pulse_alarm;
      @(negedge sys_clk);
      alarm_match = 1'b1;
      @(negedge sys_clk);
      alarm_match = 1'b0;
   endtask : pulse_alarm

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         report_and_stop();
      end
   end

   // -------------------------------------------------------------
   // test sequence
   // -------------------------------------------------------------
   initial begin
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      rd_chk(WD_ADDR, 8'h00, 8'hff);
      rd_chk(IRQEN_ADDR, 8'h00, 8'ha0);
      host.rd(13'h0100, d, oe);
      check(oe, 1'b0, "unmapped read");
      host.wr(WD_ADDR, 8'h55);
      rd_chk(WD_ADDR, 8'h55, 8'hff);
      // one period per resolution code, event steered to the interrupt pin
      for (i = 0; i < 4; i++) begin
         p = cfg[i][6:2] * (64 << (2 * cfg[i][1:0])) * SUB;
         host.wr(WD_ADDR, cfg[i]);
         wait_lo(1'b0, p + 100, n);
         check(n >= p - 8 && n <= p + 8, 1, "period");
         repeat (20) @(negedge sys_clk);
         check(irq_pin, 1'b0, "irq held");
         rd_chk(FLAGS_ADDR, 8'h80, 8'h80);
         repeat (4) @(negedge sys_clk);
         check(irq_pin, 1'b1, "irq release");
      end
      // host keeps restarting the period, so no time-out may occur
      host.wr(WD_ADDR, 8'h04);
      for (i = 0; i < 6; i++) begin
         repeat (200) @(negedge sys_clk);
         host.rd(WD_ADDR, d, oe);
      end
      rd_chk(FLAGS_ADDR, 8'h00, 8'h80);
      wait_lo(1'b0, 400, n);
      check(irq_pin, 1'b0, "time-out once restarts stop");
      host.rd(WD_ADDR, d, oe);
      repeat (3) @(negedge sys_clk);
      check(irq_pin, 1'b1, "irq cleared by access");
      rd_chk(FLAGS_ADDR, 8'h80, 8'h80);
      host.wr(WD_ADDR, 8'h00);
      repeat (700) @(negedge sys_clk);
      rd_chk(FLAGS_ADDR, 8'h00, 8'h80);
      host.wr(WD_ADDR, 8'h01);
      repeat (1200) @(negedge sys_clk);
      rd_chk(FLAGS_ADDR, 8'h00, 8'h80);
      // steered to reset with the test wave running
      host.wr(FTREG_ADDR, 8'h01);
      host.wr(WD_ADDR, 8'h84);
      count_tog(64, n);
      check(n >= 15 && n <= 17, 1, "test wave, steer one");
      wait_lo(1'b1, 400, n);
      check(rst_pin, 1'b0, "reset pulse start");
      n = 0;
      while (rst_pin === 1'b0 && n < 1000) begin
         @(negedge sys_clk);
         n++;
      end
      check(n >= 164 && n <= 819, 1, "reset pulse width");
      rd_chk(WD_ADDR, 8'h00, 8'hff);
      rd_chk(FTREG_ADDR, 8'h00, 8'h01);
      rd_chk(FLAGS_ADDR, 8'h80, 8'h80);
      // test wave with the register at zero, then denied by writing a nonzero steer-zero register
      host.wr(FTREG_ADDR, 8'h01);
      count_tog(64, n);
      check(n >= 15 && n <= 17, 1, "test wave, register zero");
      host.wr(WD_ADDR, 8'h04);
      repeat (3) @(negedge sys_clk);
      wait_lo(1'b0, 400, n);
      check(n >= 240, 1, "no wave before time-out");
      count_tog(40, n);
      check({irq_pin, n[7:0]}, 9'h000, "watchdog wins");
      host.wr(FTREG_ADDR, 8'h00);
      host.wr(WD_ADDR, 8'h00);
      rd_chk(FLAGS_ADDR, 8'h80, 8'h80);
      // alarm interrupt, clearing and battery back-up
      host.wr(IRQEN_ADDR, 8'h80);
      pulse_alarm();
      wait_lo(1'b0, 4, n);
      check(irq_pin, 1'b0, "alarm irq");
      rd_chk(FLAGS_ADDR, 8'h40, 8'h40);
      repeat (3) @(negedge sys_clk);
      check(irq_pin, 1'b1, "alarm irq release");
      rd_chk(FLAGS_ADDR, 8'h00, 8'h40);
      on_battery = 1'b1;
      pulse_alarm();
      repeat (6) @(negedge sys_clk);
      check(irq_pin, 1'b1, "no irq on battery");
      rd_chk(FLAGS_ADDR, 8'h40, 8'h40);
      host.wr(IRQEN_ADDR, 8'ha0);
      pulse_alarm();
      wait_lo(1'b0, 4, n);
      check(irq_pin, 1'b0, "irq on battery");
      rd_chk(FLAGS_ADDR, 8'h40, 8'h40);
      on_battery = 1'b0;
      // power-up transition clears enables and register, alarm still flags
      host.wr(WD_ADDR, 8'h55);
      @(negedge sys_clk);
      power_up = 1'b1;
      repeat (2) @(negedge sys_clk);
      pulse_alarm();
      power_up = 1'b0;
      rd_chk(IRQEN_ADDR, 8'h00, 8'ha0);
      rd_chk(WD_ADDR, 8'h00, 8'hff);
      rd_chk(FLAGS_ADDR, 8'h40, 8'h40);
      report_and_stop();
   end
endmodule : tb_watchdog_alarm_irq
